//--- include/snap_regs_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the snapshot register bank
// Assumes: Printed offsets are register indices; byte address is four times the index
// Notes: Guarded, definitions only
`ifndef SNAP_REGS_CONSTS_SVH
`define SNAP_REGS_CONSTS_SVH

`define IDX_SNAP_TRIGGER 12'h818
`define IDX_SNAP_READOUT 12'h819
`define IDX_IDLE_HIGH 12'h81a
`define IDX_IDLE_LOW 12'h81b
`define IDX_PAYLOAD_HIGH 12'h81c
`define IDX_PAYLOAD_LOW 12'h81d

`define TRIGGER_BIT 0
`define HIGH_FIELD_MSB 5
`define HIGH_FIELD_LSB 0
`define SNAP_BYTES 1024
`define SNAP_SUBCHANNELS 64
`define BYTES_PER_SUBCHANNEL 16

`define RST_BYTE 8'h00
`define RST_LEN 14'h0000
`define RST_PTR 10'h000

`endif

//--- include/snap_regs_pkg.sv
// Purpose: Types shared by the snapshot register bank
// Assumes: Constants come from snap_regs_consts.svh
// Notes: Types only
package snap_regs_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [13:0] len_t;
   typedef logic [9:0] ptr_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CAPTURE,
      ST_DONE
   } snap_state_e;
endpackage

//--- rtl/snap_memory.sv
// Purpose: Snapshot store of captured subchannel bytes
// Assumes: One write port, one registered read port
// Notes: Array inferred as block memory
`timescale 1ns/10ps
module snap_memory #(
   parameter int DEPTH = 1024,
   parameter int AW = 10
) (
   // Clock
   input wire logic clk_i,
   input wire logic ce_i,
   // Write side
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   // Read side
   input wire logic [AW-1:0] rd_addr_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
         end
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule // snap_memory

//--- rtl/subchannel_readout.sv
// Purpose: Wishbone register bank presenting a subchannel snapshot and Ethernet generator sizes
// Assumes: Classic Wishbone, 32-bit data, byte address = 4 * index; capture source is a byte stream
// Notes: Capture takes SNAP_BYTES cycles of sub_valid_i; reads of readout port are one-wait-state
//
// Function
// - After capture completes and trigger clears, readout shows snapshot byte zero.
// - Every readout read advances the pointer to the next ascending byte, except at the last byte, where it holds, and in the completion cycle.
// - Idle nibble count is six upper bits plus eight lower bits.
// - Payload nibble count is six upper bits plus eight lower bits.
// - Software sets trigger bit 0; device captures all subchannels, then clears it.
`timescale 1ns/10ps
`include "snap_regs_consts.svh"
module subchannel_readout
   import snap_regs_pkg::*;
#(
   parameter int SNAP_DEPTH = `SNAP_BYTES,
   parameter int PTR_W = 10
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [13:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   // Subchannel byte stream to capture
   input wire logic sub_valid_i,
   input wire snap_regs_pkg::byte_t sub_byte_i,
   // Generator sizing and capture status
   output snap_regs_pkg::len_t idle_nibbles_o,
   output snap_regs_pkg::len_t payload_nibbles_o,
   output logic capture_busy_o
);
   import snap_regs_pkg::*;

   typedef struct packed {
      snap_state_e state;
      logic trigger;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic rd_pend;
      logic [5:0] idle_high;
      byte_t idle_low;
      logic [5:0] payload_high;
      byte_t payload_low;
      logic [31:0] dat;
      logic ack;
      logic err;
      len_t idle_len;
      len_t payload_len;
      logic busy;
   } state_s;

   state_s r;
   state_s next_r;
   byte_t mem_q;
   logic wr_en;
   logic req;
   logic [11:0] idx;

   assign req = cyc_i && stb_i && !r.ack && !r.err && !r.rd_pend;
   assign idx = adr_i[13:2];
   assign wr_en = (r.state == ST_CAPTURE) && sub_valid_i;

   snap_memory #(
      .DEPTH(SNAP_DEPTH),
      .AW(PTR_W)
   ) u_mem (
      .clk_i(clk_i),
      .ce_i(ce_i),
      .wr_en_i(wr_en),
      .wr_addr_i(r.wr_ptr),
      .wr_data_i(sub_byte_i),
      .rd_addr_i(r.rd_ptr),
      .rd_data_o(mem_q)
   );

   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      next_r.err = 1'b0;

      // Capture engine
      unique case (r.state)
         ST_IDLE: begin
            if (r.trigger) begin
               next_r.state = ST_CAPTURE;
               next_r.wr_ptr = PTR_W'(`RST_PTR);
            end
         end
         ST_CAPTURE: begin
            if (sub_valid_i) begin
               next_r.wr_ptr = r.wr_ptr + PTR_W'(1);
               if (r.wr_ptr == PTR_W'(SNAP_DEPTH - 1)) begin
                  next_r.state = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            next_r.trigger = 1'b0;
            next_r.rd_ptr = PTR_W'(`RST_PTR);
            next_r.state = ST_IDLE;
         end
      endcase

      // Readout data lags address by one cycle in the memory, so reads wait one state
      if (r.rd_pend) begin
         next_r.rd_pend = 1'b0;
         next_r.ack = 1'b1;
         next_r.dat = {24'h000000, mem_q};
         // Completion restart wins over a read finishing in the same cycle
         if (r.state != ST_DONE && r.rd_ptr != PTR_W'(SNAP_DEPTH - 1)) begin
            next_r.rd_ptr = r.rd_ptr + PTR_W'(1);
         end
      end else if (req) begin
         next_r.ack = 1'b1;
         next_r.dat = 32'h00000000;
         if (we_i) begin
            if (sel_i[0]) begin
               unique case (idx)
                  `IDX_SNAP_TRIGGER: begin
                     // Writes during capture ignored so completion is not lost
                     if (r.state == ST_IDLE) begin
                        next_r.trigger = dat_i[`TRIGGER_BIT];
                     end
                  end
                  `IDX_IDLE_HIGH: next_r.idle_high = dat_i[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
                  `IDX_IDLE_LOW: next_r.idle_low = dat_i[7:0];
                  `IDX_PAYLOAD_HIGH: next_r.payload_high = dat_i[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB];
                  `IDX_PAYLOAD_LOW: next_r.payload_low = dat_i[7:0];
                  `IDX_SNAP_READOUT: begin
                  end
                  default: begin
                     next_r.ack = 1'b0;
                     next_r.err = 1'b1;
                  end
               endcase
            end
         end else begin
            unique case (idx)
               `IDX_SNAP_TRIGGER: next_r.dat = {31'h00000000, r.trigger};
               `IDX_SNAP_READOUT: begin
                  next_r.ack = 1'b0;
                  next_r.rd_pend = 1'b1;
               end
               `IDX_IDLE_HIGH: next_r.dat = {26'h0000000, r.idle_high};
               `IDX_IDLE_LOW: next_r.dat = {24'h000000, r.idle_low};
               `IDX_PAYLOAD_HIGH: next_r.dat = {26'h0000000, r.payload_high};
               `IDX_PAYLOAD_LOW: next_r.dat = {24'h000000, r.payload_low};
               default: begin
                  next_r.ack = 1'b0;
                  next_r.err = 1'b1;
               end
            endcase
         end
      end

      next_r.idle_len = {r.idle_high, r.idle_low};
      next_r.payload_len = {r.payload_high, r.payload_low};
      next_r.busy = (r.state != ST_IDLE) || r.trigger;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '{state: ST_IDLE, trigger: 1'b0, wr_ptr: PTR_W'(`RST_PTR), rd_ptr: PTR_W'(`RST_PTR),
                rd_pend: 1'b0, idle_high: 6'h00, idle_low: `RST_BYTE, payload_high: 6'h00, payload_low: `RST_BYTE,
                dat: 32'h00000000, ack: 1'b0, err: 1'b0, idle_len: `RST_LEN, payload_len: `RST_LEN,
                busy: 1'b0};
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign dat_o = r.dat;
   assign ack_o = r.ack;
   assign err_o = r.err;
   assign idle_nibbles_o = r.idle_len;
   assign payload_nibbles_o = r.payload_len;
   assign capture_busy_o = r.busy;
endmodule // subchannel_readout

//--- test/subchannel_readout_checker.sv
// Purpose: Port-level assertions for the snapshot register bank
// Assumes: ce_i held high; answers as in the hand-over timing
// Notes: Bound to every instance
`timescale 1ns/10ps
module subchannel_readout_checker (
   // Bus side
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [13:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Outputs to the generator
   input wire snap_regs_pkg::len_t idle_nibbles_o,
   input wire snap_regs_pkg::len_t payload_nibbles_o,
   input wire logic capture_busy_o,
   // Capture stream
   input wire logic sub_valid_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_idle_low:
   assert property (ack_o && we_i && sel_i[0] && adr_i == 14'h206c |-> ##2
      idle_nibbles_o[7:0] == $past(dat_i[7:0], 2)) else $error("idle low byte lost");
   a_pay_high:
   assert property (ack_o && we_i && sel_i[0] && adr_i == 14'h2070 |-> ##2
      payload_nibbles_o[13:8] == $past(dat_i[5:0], 2)) else $error("payload high bits lost");
   a_trig_busy:
   assert property (ack_o && we_i && sel_i[0] && dat_i[0] && adr_i == 14'h2060 |-> ##[1:2] capture_busy_o)
      else $error("capture not started");
   // Capture length follows the byte stream, so busy ending is tied to the last beat
   a_busy_ends:
   assert property ($fell(capture_busy_o) |-> $past(sub_valid_i, 3)) else $error("capture ended without last byte");
   a_read_wait:
   assert property ($rose(stb_i) && cyc_i && !we_i && adr_i == 14'h2064 |-> ##1 !ack_o ##1 ack_o)
      else $error("readout answer late or early");
   a_trig_clear:
   assert property (ack_o && !we_i && adr_i == 14'h2060 && !$past(capture_busy_o, 2) |-> !dat_o[0])
      else $error("trigger not cleared");
endmodule // subchannel_readout_checker
bind subchannel_readout subchannel_readout_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
   .sel_i, .dat_i, .dat_o, .ack_o, .idle_nibbles_o, .payload_nibbles_o, .capture_busy_o, .sub_valid_i);

//--- test/test_subchannel_readout.sv
// Purpose: Self-checking bench for the snapshot register bank
// Assumes: Snapshot depth shortened to 16 bytes
// Notes: Two captures show the pointer restart
`timescale 1ns/10ps
module test_subchannel_readout;
   import snap_regs_pkg::*;
   localparam int D = 16;
   logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sub_valid_i = 0, ack_o, err_o, capture_busy_o;
   logic [13:0] adr_i = 0;
   logic [3:0] sel_i = 4'hf;
   logic [31:0] dat_i = 0, dat_o, q;
   byte_t sub_byte_i = 0;
   len_t idle_nibbles_o, payload_nibbles_o;
   int mismatches = 0, check_count = 0;
   always #12.5 clk_i = ~clk_i;
   subchannel_readout #(.SNAP_DEPTH(D), .PTR_W(4)) u_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
      .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .sub_valid_i, .sub_byte_i, .idle_nibbles_o, .payload_nibbles_o,
      .capture_busy_o);
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   // Holds the request until ack or err is sampled
   task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d, output logic e);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1 && err_o !== 1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         report_and_stop;
      end
      q = dat_o; e = err_o;
      cyc_i <= 0; stb_i <= 0;
   endtask
   task automatic t_regs;
      logic [13:0] a[4] = '{14'h2068, 14'h206c, 14'h2070, 14'h2074};
      logic [7:0] d[4] = '{8'hff, 8'ha5, 8'h2a, 8'h5c};
      logic e;
      chk("idle rst", 0, idle_nibbles_o);
      for (int i = 0; i < 4; i++) wb(1, a[i], {24'h0, d[i]}, e);
      repeat (3) @(posedge clk_i);
      chk("idle", 14'h3fa5, idle_nibbles_o);
      chk("payload", 14'h2a5c, payload_nibbles_o);
      wb(0, 14'h206c, 0, e);
      chk("idle low rd", 8'ha5, q[7:0]);
      wb(0, 14'h2080, 0, e);
      chk("unmapped err", 1, e);
      $display("t_regs done");
   endtask
   task automatic t_snap(input byte_t s);
      logic e;
      wb(1, 14'h2060, 1, e);
      repeat (2) @(posedge clk_i);
      chk("busy", 1, capture_busy_o);
      for (int i = 0; i < D; i++) begin
         sub_valid_i <= 1;
         sub_byte_i <= s + 8'(i);
         @(posedge clk_i);
      end
      sub_valid_i <= 0;
      // Stale read data must not end the poll before the first read
      q = 32'hffffffff;
      for (int i = 0; i < 20 && q[0] !== 0; i++) wb(0, 14'h2060, 0, e);
      chk("trigger", 0, q[0]);
      chk("busy end", 0, capture_busy_o);
      // Two reads past the end show saturation
      for (int i = 0; i < D + 2; i++) begin
         wb(0, 14'h2064, 0, e);
         chk("readout", s + 8'(i < D ? i : D - 1), q[7:0]);
      end
      $display("t_snap done");
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      t_regs;
      t_snap(8'h10);
      t_snap(8'hc3);
      report_and_stop;
   end
endmodule // test_subchannel_readout
